/* hw/remote_local_interface.sv */
// Contract
// - Lockout in remote ignores local key
// - REN false leaves remote, clears lockout
// - Ratio code while remote listener selects ratio
// - Device clear selects AC level, keeps state
// - Abort drops listener and addressed indication
// - Abort alone keeps remote
// - After REN false, talk address gives local
// - Abort drops talker; with REN false, indications go off
// - Poll enable command sets poll flag
// - Abort clears serial poll flag
// - Polled talker returns status byte
// - Remote on own listen address with REN
// - Lockout in remote disables all front panel keys
// - Universal commands work when unaddressed
`timescale 1ns/100ps
`default_nettype none
`include "remote_local_defs.svh"
module remote_local_interface
    import remote_local_pkg::*;
#(
    parameter logic [4:0] MY_ADDR = `MY_ADDR_DEFAULT
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire bus_byte_s  rx,
    input  wire logic       ren,
    input  wire logic       ifc,
    input  wire logic       local_key,
    input  wire logic [15:0] special_function_key,
    input  wire logic       special_key_strobe,
    input  wire logic [7:0] service_status,
    input  wire logic       talk_req,
    output var  ind_s       ind,
    output var  logic       addressed,
    output var  logic       keys_disabled,
    output var  meas_e      meas,
    output var  logic [7:0] status_byte,
    output var  logic       status_valid,
    output var  logic [3:0] special_readout
);
    logic       listen_reg;
    logic       talk_reg;
    logic       remote_reg;
    logic       lockout_reg;
    logic       spoll_reg;
    logic       prefix_reg;
    logic       listen_next;
    logic       talk_next;
    logic       remote_next;
    logic       lockout_next;
    logic       spoll_next;
    logic       prefix_next;
    meas_e      meas_next;
    logic [3:0] readout_next;

    wire cmd        = rx.valid && rx.atn;
    wire data       = rx.valid && !rx.atn;
    wire [7:0] grp  = rx.data & `CMD_ADDR_MASK;
    wire my_listen  = cmd && grp == `CMD_LISTEN_GROUP && rx.data[4:0] == MY_ADDR;
    wire oth_listen = cmd && grp == `CMD_LISTEN_GROUP && rx.data[4:0] != MY_ADDR;
    wire my_talk    = cmd && grp == `CMD_TALK_GROUP && rx.data[4:0] == MY_ADDR;
    wire oth_talk   = cmd && grp == `CMD_TALK_GROUP && rx.data[4:0] != MY_ADDR;
    wire unlisten   = cmd && rx.data == `CMD_UNLISTEN;
    wire untalk     = cmd && rx.data == `CMD_UNTALK;
    wire dev_clear  = cmd && (rx.data == `CMD_DCL || (rx.data == `CMD_SDC && listen_reg));
    wire key_ok     = !(remote_reg && lockout_reg);
    wire local_go   = local_key && key_ok;

    always_comb begin
        listen_next = listen_reg;
        talk_next   = talk_reg;
        if (my_listen) listen_next = 1'b1;
        else if (oth_listen || unlisten) listen_next = 1'b0;
        if (my_talk) begin
            talk_next   = 1'b1;
            listen_next = 1'b0;
        end else if (oth_talk || untalk) begin
            talk_next = 1'b0;
        end
        if (my_listen) talk_next = 1'b0;
        if (ifc) begin
            listen_next = 1'b0;
            talk_next   = 1'b0;
        end
    end

    always_comb begin
        remote_next = remote_reg;
        if (ren && my_listen) remote_next = 1'b1;
        if (!ren || local_go) remote_next = 1'b0;
    end

    // Lockout latched regardless of addressing; only REN false lifts it
    assign lockout_next = !ren ? 1'b0 : ((cmd && rx.data == `CMD_LLO) ? 1'b1 : lockout_reg);

    always_comb begin
        spoll_next = spoll_reg;
        if (cmd && rx.data == `CMD_SPE) spoll_next = 1'b1;
        if (cmd && rx.data == `CMD_SPD) spoll_next = 1'b0;
        if (ifc) spoll_next = 1'b0;
    end

    // Two-character code parsed from consecutive data bytes
    assign prefix_next = data && listen_reg ? (rx.data == `CHAR_MEAS_PREFIX) : prefix_reg;

    always_comb begin
        meas_next = meas;
        if (data && listen_reg && remote_reg && prefix_reg && rx.data == `CHAR_RATIO_DIGIT)
            meas_next = MEAS_RATIO;
        if (dev_clear) meas_next = MEAS_AC_LEVEL;
    end

    assign readout_next = (special_key_strobe && key_ok &&
                           special_function_key == `SPECIAL_SERIAL_POLL)
                          ? {3'b000, spoll_next} : special_readout;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            listen_reg      <= 1'b0;
            talk_reg        <= 1'b0;
            remote_reg      <= 1'b0;
            lockout_reg     <= 1'b0;
            spoll_reg       <= 1'b0;
            prefix_reg      <= 1'b0;
            meas            <= MEAS_AC_LEVEL;
            ind             <= '0;
            addressed       <= 1'b0;
            keys_disabled   <= 1'b0;
            status_byte     <= `STATUS_RESET;
            status_valid    <= 1'b0;
            special_readout <= 4'h0;
        end else begin
            listen_reg      <= listen_next;
            talk_reg        <= talk_next;
            remote_reg      <= remote_next;
            lockout_reg     <= lockout_next;
            spoll_reg       <= spoll_next;
            prefix_reg      <= prefix_next;
            meas            <= meas_next;
            ind             <= '{remote_next, listen_next || talk_next, lockout_next, spoll_next};
            addressed       <= listen_next || talk_next;
            keys_disabled   <= remote_next || (remote_next && lockout_next);
            status_byte     <= service_status;
            status_valid    <= talk_next && spoll_next && talk_req;
            special_readout <= readout_next;
        end
    end

    sequence remote_entry_s;
        ren && my_listen && !ifc && !local_key;
    endsequence

    // Both bytes of the code must arrive back to back while listening
    sequence ratio_code_s;
        data && listen_reg && rx.data == `CHAR_MEAS_PREFIX
        ##1 data && listen_reg && remote_reg && rx.data == `CHAR_RATIO_DIGIT && !ifc;
    endsequence

    remote_on_a: assert property (@(posedge ref_clk) disable iff (rst)
        remote_entry_s |=> ind.remote && addressed) else $error("remote entry failed");
    lockout_key_a: assert property (@(posedge ref_clk) disable iff (rst)
        ren && remote_reg && lockout_reg && local_key && (listen_reg || talk_reg)
        && !ifc && !cmd |=> ind.remote && addressed)
        else $error("local key not ignored");
    ren_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ren |=> !ind.remote && !ind.lockout) else $error("ren false kept remote");
    ifc_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        ifc && ren && remote_reg && !local_key |=> ind.remote && !addressed)
        else $error("abort changed remote");
    ratio_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        data && listen_reg && remote_reg && prefix_reg && rx.data == `CHAR_RATIO_DIGIT
        && !ifc |=> meas == MEAS_RATIO) else $error("ratio not selected");
    clear_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        dev_clear && ren && !local_key |=> meas == MEAS_AC_LEVEL && $stable(ind.remote))
        else $error("device clear wrong");
    spoll_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd && rx.data == `CMD_SPE && !ifc |=> ind.serial_poll) else $error("poll flag not set");
    spoll_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
        ifc |=> !ind.serial_poll && !addressed) else $error("abort kept poll or address");
    status_out_a: assert property (@(posedge ref_clk) disable iff (rst)
        status_valid |-> $past(talk_req) && ind.serial_poll) else $error("status without poll");

    ratio_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
        ratio_code_s |=> meas == MEAS_RATIO) else $error("ratio code pair missed");

    listen_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        ifc && listen_reg |=> !addressed) else $error("abort kept listener");

    talk_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        ifc && talk_reg && !ren |=> !ind.remote && !addressed) else $error("abort kept talker");

    talk_local_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ren && my_talk && !ifc |=> !ind.remote && addressed) else $error("talk not local");

    keys_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        ind.remote && ind.lockout |-> keys_disabled) else $error("keys live in lockout");

    llo_any_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd && rx.data == `CMD_LLO && ren |=> ind.lockout) else $error("lockout not taken");

    // Selected clear needs the listener; a stray one must not touch the measurement
    sdc_refused_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd && rx.data == `CMD_SDC && !listen_reg |=> $stable(meas))
        else $error("selected clear not refused");

    local_go_a: assert property (@(posedge ref_clk) disable iff (rst)
        local_go |=> !ind.remote) else $error("local key not taken");

    spd_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd && rx.data == `CMD_SPD |=> !ind.serial_poll) else $error("poll disable missed");

    status_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
        status_valid |-> status_byte == $past(service_status)) else $error("status byte wrong");

    rst_state_a: assert property (@(posedge ref_clk)
        rst |=> ind == '0 && !addressed && meas == MEAS_AC_LEVEL
        && status_byte == `STATUS_RESET && !status_valid) else $error("reset state wrong");
endmodule : remote_local_interface
`default_nettype wire

/* hw/remote_local_defs.svh */
`ifndef REMOTE_LOCAL_DEFS_SVH
`define REMOTE_LOCAL_DEFS_SVH
`define MY_ADDR_DEFAULT     5'h1C
`define CMD_ADDR_MASK       8'h60
`define CMD_LISTEN_GROUP    8'h20
`define CMD_TALK_GROUP      8'h40
`define CMD_UNLISTEN        8'h3F
`define CMD_UNTALK          8'h5F
`define CMD_LLO             8'h11
`define CMD_DCL             8'h14
`define CMD_SDC             8'h04
`define CMD_SPE             8'h18
`define CMD_SPD             8'h19
`define CHAR_MEAS_PREFIX    8'h4D
`define CHAR_RATIO_DIGIT    8'h32
`define SPECIAL_SERIAL_POLL 16'h0613
`define STATUS_RESET        8'h00
`endif

/* hw/remote_local_pkg.sv */
`default_nettype none
package remote_local_pkg;
    typedef enum logic [1:0] {
        MEAS_AC_LEVEL = 2'b00,
        MEAS_RATIO    = 2'b01,
        MEAS_OTHER    = 2'b10
    } meas_e;
    typedef struct packed {
        logic       valid;
        logic       atn;
        logic [7:0] data;
    } bus_byte_s;
    typedef struct packed {
        logic remote;
        logic addressed;
        logic lockout;
        logic serial_poll;
    } ind_s;
endpackage : remote_local_pkg
`default_nettype wire

/* bench/bus_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bus_ctrl_model
    import remote_local_pkg::*;
(
    input  wire logic      ref_clk,
    output var  bus_byte_s rx
);
    initial rx = '0;
    // Released lines show inverted data, never the stale byte
    task automatic put(input logic a, input logic [7:0] d, input logic last);
        rx = '{1'b1, a, d};
        @(posedge ref_clk);
        #1;
        if (last) rx = '{1'b0, 1'b0, ~d};
    endtask : put
endmodule : bus_ctrl_model
`default_nettype wire

/* bench/tb_ieee488_remote_local_interface.sv */
`timescale 1ns/100ps
`default_nettype none
`include "remote_local_defs.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
    $display("Error %s exp %h got %h", n, e, a); bad_count++; end end
module tb_ieee488_remote_local_interface
    import remote_local_pkg::*;
;
    logic        ref_clk, rst, ren, ifc, local_key, strobe, talk_req;
    logic [15:0] sf_code;
    logic [7:0]  svc, status_byte;
    logic [3:0]  readout;
    logic        addressed, keys_disabled, status_valid;
    bus_byte_s   rx;
    ind_s        ind;
    meas_e       meas;
    int          bad_count = 0;
    int          tests_run = 0;
    bus_ctrl_model ctl_u (.ref_clk(ref_clk), .rx(rx));
    remote_local_interface dut_u (.ref_clk(ref_clk), .rst(rst), .rx(rx), .ren(ren),
        .ifc(ifc), .local_key(local_key), .special_function_key(sf_code),
        .special_key_strobe(strobe), .service_status(svc), .talk_req(talk_req),
        .ind(ind), .addressed(addressed), .keys_disabled(keys_disabled), .meas(meas),
        .status_byte(status_byte), .status_valid(status_valid),
        .special_readout(readout));
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] addr(input logic talk);
        return (talk ? `CMD_TALK_GROUP : `CMD_LISTEN_GROUP) | {3'h0, `MY_ADDR_DEFAULT};
    endfunction : addr
    function automatic logic [7:0] other_listen(input logic [4:0] a);
        return `CMD_LISTEN_GROUP | {3'h0, (a == `MY_ADDR_DEFAULT) ? ~a : a};
    endfunction : other_listen
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic pulse(ref logic s);
        s = 1;
        step();
        s = 0;
    endtask : pulse
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask : done
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic poll(input logic [7:0] s);
        svc = s;
        ctl_u.put(1'b1, `CMD_SPE, 1'b1);
        `CHK("poll_flag", 1'b1, ind.serial_poll)
        sf_code = `SPECIAL_SERIAL_POLL;
        pulse(strobe);
        `CHK("readout", 4'h1, readout)
        pulse(talk_req);
        `CHK("stat_valid", 1'b1, status_valid)
        `CHK("stat_byte", s, status_byte)
    endtask : poll
    initial begin
        #500_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        {rst, ren, ifc, local_key, strobe, talk_req, sf_code, svc} = {1'b1, 29'h0};
        void'($urandom(74));
        repeat (12) step();
        rst = 0;
        `CHK("ind_rst", 4'h0, ind)
        `CHK("meas_rst", MEAS_AC_LEVEL, meas)
        done("reset");
        ren = 1;
        ctl_u.put(1'b1, addr(0), 1'b1);
        `CHK("remote_on", 2'b11, {ind.remote, addressed})
        ctl_u.put(1'b0, `CHAR_MEAS_PREFIX, 1'b0);
        ctl_u.put(1'b0, `CHAR_RATIO_DIGIT, 1'b1);
        `CHK("meas_ratio", MEAS_RATIO, meas)
        ctl_u.put(1'b1, `CMD_DCL, 1'b1);
        `CHK("meas_clr", MEAS_AC_LEVEL, meas)
        `CHK("clr_state", 2'b11, {ind.remote, addressed})
        ctl_u.put(1'b1, `CMD_LLO, 1'b1);
        pulse(local_key);
        `CHK("keys_off", 1'b1, keys_disabled)
        `CHK("lockout", 2'b11, {ind.remote, addressed})
        ren = 0;
        step();
        `CHK("ren_off", 3'b001, {ind.remote, ind.lockout, addressed})
        done("remote");
        ctl_u.put(1'b1, addr(1), 1'b1);
        `CHK("talk_local", 2'b01, {ind.remote, addressed})
        poll(8'h00);
        done("local_poll");
        pulse(ifc);
        `CHK("ifc_talk", 3'b000, {ind.remote, addressed, ind.serial_poll})
        pulse(strobe);
        `CHK("readout_off", 4'h0, readout)
        ren = 1;
        ctl_u.put(1'b1, addr(0), 1'b1);
        pulse(ifc);
        `CHK("ifc_listen", 2'b10, {ind.remote, addressed})
        done("abort");
        ctl_u.put(1'b1, addr(1), 1'b1);
        poll(8'($urandom));
        done("remote_poll");
        repeat (4) begin
            ctl_u.put(1'b1, addr(0), 1'b0);
            ctl_u.put(1'b0, `CHAR_MEAS_PREFIX, 1'b0);
            ctl_u.put(1'b0, `CHAR_RATIO_DIGIT, 1'b0);
            ctl_u.put(1'b1, other_listen(5'($urandom)), 1'b1);
            `CHK("unaddr", 2'b10, {ind.remote, addressed})
            `CHK("meas_held", MEAS_RATIO, meas)
            ctl_u.put(1'b1, `CMD_SDC, 1'b1);
            `CHK("sdc_refused", MEAS_RATIO, meas)
            ctl_u.put(1'b1, `CMD_DCL, 1'b1);
            `CHK("dcl_unaddr", MEAS_AC_LEVEL, meas)
        end
        done("unaddressed");
        report_and_stop();
    end
endmodule : tb_ieee488_remote_local_interface
`default_nettype wire
